//--- common/fsra_consts.svh
`ifndef FSRA_CONSTS_SVH
`define FSRA_CONSTS_SVH
`define FSRA_OP_RD1      8'h05
`define FSRA_OP_RD2      8'h35
`define FSRA_OP_RD3      8'h15
`define FSRA_OP_RDIND    8'h65
`define FSRA_OP_WR1      8'h01
`define FSRA_OP_WR2      8'h31
`define FSRA_OP_WR3      8'h11
`define FSRA_OP_WREN     8'h06
`define FSRA_OP_WRVOL    8'h50
`define FSRA_ADDR_SR1    8'h01
`define FSRA_ADDR_SR2    8'h02
`define FSRA_ADDR_SR3    8'h03
`define FSRA_ADDR_SR4    8'h04
`define FSRA_ADDR_SR5    8'h05
`define FSRA_WEL_BIT     1
`define FSRA_RESET_SR    8'h00
`define FSRA_UNDEF_DATA  8'h00
`define FSRA_BIT_LAST    3'h7
`define FSRA_BIT_FIRST   3'h7
`define FSRA_BIT_START   3'h0
`define FSRA_WR_NONE     2'h0
`define FSRA_WR_ONE      2'h1
`define FSRA_WR_TWO      2'h2
`define FSRA_WR_CAP      2'h3
`define FSRA_PIN_IDLE    3'h4
`endif

//--- common/fsra_pkg.sv
package fsra_pkg;
  typedef enum logic [2:0] {
    FSRA_ST_OPCODE = 3'b000,
    FSRA_ST_RDDIR  = 3'b001,
    FSRA_ST_ADDR   = 3'b010,
    FSRA_ST_DUMMY  = 3'b011,
    FSRA_ST_RDIND  = 3'b100,
    FSRA_ST_WRDATA = 3'b101,
    FSRA_ST_IGNORE = 3'b110
  } fsra_state_type;

  typedef struct packed {
    logic       cs_n;
    logic       sck;
    logic       si;
  } fsra_pins_type;

  typedef struct packed {
    logic [7:0] sr5;
    logic [7:0] sr4;
    logic [7:0] sr3;
    logic [7:0] sr2;
    logic [7:0] sr1;
  } fsra_regs_type;
endpackage

//--- design/fsra_top.sv
// What this block does
// [RULE1] direct reads: opcodes 05h 35h 15h, msb first
// [RULE2] 05h/35h/15h select registers one/two/three
// [RULE3] direct read byte repeats from bit 7
// [RULE4] every repeat shows live register contents
// [RULE5] select high ends read, output tri-stated
// [RULE6] 65h, address byte, dummy, then data
// [RULE7] address byte eight bits, msb first
// [RULE8] opcode, address, dummy; data clocks 24-31
// [RULE9] address increments after each output byte
// [RULE10] addresses past five return undefined data
// [RULE11] address wraps from FFh to 00h
// [RULE12] direct writes: 01h 31h 11h, msb first
// [RULE13] 50h arms volatile write, once, no latch
// [RULE14] 06h sets write latch before write
// [RULE15] select high after write clears write latch
// [RULE16] host sends whole write before select high
// [RULE17] partial byte at select high aborts write
// [RULE18] 01h with two bytes also writes reg two
// [RULE19] sample rising edge, shift out falling edge
`timescale 1ns/100ps
`include "fsra_consts.svh"

module fsra_top (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        cs_b_pin,
  input  wire logic        sck_pin,
  input  wire logic        si_pin,
  input  wire logic [7:0]  live_sr4,
  input  wire logic [7:0]  live_sr5,
  output logic             so_out_q,
  output logic             so_oe_q,
  output logic             write_latch_flag_q,
  output logic             vol_armed_q,
  output logic [7:0]       status_byte_one_q,
  output logic [7:0]       status_byte_two_q,
  output logic [7:0]       status_byte_three_q
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // sck is sampled, so each of its phases must last at least three
  // ref_clk periods; a faster link loses edges
  fsra_pkg::fsra_pins_type pins_meta_q;
  fsra_pkg::fsra_pins_type pins_sync_q;
  logic                    sck_prev_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pins_meta_q <= `FSRA_PIN_IDLE;
      pins_sync_q <= `FSRA_PIN_IDLE;
      sck_prev_q  <= 1'b0;
    end else begin
      pins_meta_q <= {cs_b_pin, sck_pin, si_pin};
      pins_sync_q <= pins_meta_q;
      sck_prev_q  <= pins_sync_q.sck;
    end
  end

  // ------------------------------------------------------------
  // link edge detection
  // ------------------------------------------------------------
  // edges only count inside a frame, so sck may idle low or high
  logic sel;
  logic rise;
  logic fall;
  logic cs_rise;
  logic cs_prev_q;

  assign sel     = !pins_sync_q.cs_n;
  assign rise    = sel && pins_sync_q.sck && !sck_prev_q; // RULE19
  assign fall    = sel && !pins_sync_q.sck && sck_prev_q; // RULE19
  assign cs_rise = pins_sync_q.cs_n && !cs_prev_q;

  // cs_rise ends a frame: commits and latch changes wait for it
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cs_prev_q <= 1'b1;
    end else begin
      cs_prev_q <= pins_sync_q.cs_n;
    end
  end

  // ------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------
  // sr1 carries the live write latch so every repeat is current
  function automatic logic [7:0] reg_byte(input logic [7:0] addr,
                                          input fsra_pkg::fsra_regs_type r);
    case (addr)
      `FSRA_ADDR_SR1: reg_byte = r.sr1;
      `FSRA_ADDR_SR2: reg_byte = r.sr2;
      `FSRA_ADDR_SR3: reg_byte = r.sr3;
      `FSRA_ADDR_SR4: reg_byte = r.sr4;
      `FSRA_ADDR_SR5: reg_byte = r.sr5;
      default:        reg_byte = `FSRA_UNDEF_DATA; // RULE10
    endcase
  endfunction

  fsra_pkg::fsra_regs_type live_regs;
  always_comb begin
    live_regs.sr1 = status_byte_one_q;
    live_regs.sr1[`FSRA_WEL_BIT] = write_latch_flag_q;
    live_regs.sr2 = status_byte_two_q;
    live_regs.sr3 = status_byte_three_q;
    live_regs.sr4 = live_sr4;
    live_regs.sr5 = live_sr5;
  end

  // ------------------------------------------------------------
  // command sequencer
  // ------------------------------------------------------------
  fsra_pkg::fsra_state_type state_q;
  logic [2:0]  bit_cnt_q;
  logic [7:0]  shift_in_q;
  logic [7:0]  opcode_q;
  logic [7:0]  addr_q;
  logic [1:0]  wr_bytes_q;
  logic [7:0]  wr_data0_q;
  logic [7:0]  wr_data1_q;
  logic [7:0]  shifted;
  logic        byte_done;

  assign shifted   = {shift_in_q[6:0], pins_sync_q.si}; // RULE7
  assign byte_done = rise && (bit_cnt_q == `FSRA_BIT_LAST);

  // leaving select clears all frame state; any direct write frame, cut or whole, still drops the latch and arm
  always_ff @(posedge ref_clk) begin
    if (!rst_b || !sel) begin
      state_q    <= fsra_pkg::FSRA_ST_OPCODE;
      bit_cnt_q  <= 3'h0;
      shift_in_q <= 8'h00;
      opcode_q   <= 8'h00;
      addr_q     <= 8'h00;
      wr_bytes_q <= 2'h0;
      wr_data0_q <= 8'h00;
      wr_data1_q <= 8'h00;
    end else if (rise) begin
      shift_in_q <= shifted;
      bit_cnt_q  <= bit_cnt_q + 3'h1;
      if (byte_done) begin
        case (state_q)
          fsra_pkg::FSRA_ST_OPCODE: begin
            opcode_q <= shifted;
            case (shifted)
              `FSRA_OP_RD1, `FSRA_OP_RD2, `FSRA_OP_RD3: // RULE1
                state_q <= fsra_pkg::FSRA_ST_RDDIR;
              `FSRA_OP_RDIND:
                state_q <= fsra_pkg::FSRA_ST_ADDR; // RULE6
              `FSRA_OP_WR1, `FSRA_OP_WR2, `FSRA_OP_WR3: // RULE12
                state_q <= fsra_pkg::FSRA_ST_WRDATA;
              // unknown opcodes are ignored to the end of the frame
              default:
                state_q <= fsra_pkg::FSRA_ST_IGNORE;
            endcase
          end
          fsra_pkg::FSRA_ST_ADDR: begin
            addr_q  <= shifted; // RULE8
            state_q <= fsra_pkg::FSRA_ST_DUMMY;
          end
          fsra_pkg::FSRA_ST_DUMMY: begin
            state_q <= fsra_pkg::FSRA_ST_RDIND; // RULE8
          end
          fsra_pkg::FSRA_ST_RDIND: begin
            // eight-bit counter wraps from FFh to 00h by itself
            addr_q <= addr_q + 8'h01; // RULE9 RULE11
          end
          fsra_pkg::FSRA_ST_WRDATA: begin
            // bytes past the second are dropped; the count stops at three
            if (wr_bytes_q == `FSRA_WR_NONE) begin
              wr_data0_q <= shifted;
            end else if (wr_bytes_q == `FSRA_WR_ONE) begin
              wr_data1_q <= shifted; // RULE18
            end
            if (wr_bytes_q != `FSRA_WR_CAP) begin
              wr_bytes_q <= wr_bytes_q + 2'h1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // direct-read register select
  // ------------------------------------------------------------
  logic [7:0] dir_addr;
  always_comb begin
    case (opcode_q)
      `FSRA_OP_RD2: dir_addr = `FSRA_ADDR_SR2; // RULE2
      `FSRA_OP_RD3: dir_addr = `FSRA_ADDR_SR3; // RULE2
      default:      dir_addr = `FSRA_ADDR_SR1; // RULE2
    endcase
  end

  // ------------------------------------------------------------
  // serial output
  // ------------------------------------------------------------
  // byte is latched on the first falling edge so each repeat is fresh
  // so_out_q only means something while so_oe_q is high
  logic [7:0] out_byte_q;
  logic [2:0] out_idx_q;
  logic       reading;
  logic [7:0] load_byte;

  assign reading = (state_q == fsra_pkg::FSRA_ST_RDDIR) ||
                   (state_q == fsra_pkg::FSRA_ST_RDIND);
  assign load_byte = (state_q == fsra_pkg::FSRA_ST_RDDIR)
                     ? reg_byte(dir_addr, live_regs)
                     : reg_byte(addr_q, live_regs); // RULE4

  always_ff @(posedge ref_clk) begin
    if (!rst_b || !sel) begin
      so_oe_q    <= 1'b0; // RULE5
      so_out_q   <= 1'b0;
      out_idx_q  <= `FSRA_BIT_FIRST;
      out_byte_q <= 8'h00;
    end else if (fall && reading) begin
      so_oe_q <= 1'b1;
      if (out_idx_q == `FSRA_BIT_FIRST) begin
        out_byte_q <= load_byte; // RULE4
        so_out_q   <= load_byte[`FSRA_BIT_FIRST];
      end else begin
        so_out_q <= out_byte_q[out_idx_q];
      end
      out_idx_q <= out_idx_q - 3'h1; // RULE3
    end
  end

  // ------------------------------------------------------------
  // write latch and volatile arm
  // ------------------------------------------------------------
  logic is_wr;
  logic commit;
  logic on_byte_edge;
  logic op_end;

  // 01h 31h 11h, the only frames that may touch the registers
  function automatic logic dir_write_op(input logic [7:0] op);
    dir_write_op = (op == `FSRA_OP_WR1) || (op == `FSRA_OP_WR2) ||
                   (op == `FSRA_OP_WR3);
  endfunction

  assign is_wr        = dir_write_op(opcode_q);
  assign on_byte_edge = (bit_cnt_q == `FSRA_BIT_START);
  // 06h and 50h only count when their frame ends on a byte edge
  assign op_end       = cs_rise && on_byte_edge;
  // commit waits for cs rise so a cut last byte can still abort
  assign commit       = op_end && is_wr && (wr_bytes_q != `FSRA_WR_NONE) &&
                        (write_latch_flag_q || vol_armed_q); // RULE17

  // the latch drops after any direct write frame, aborted or not
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      write_latch_flag_q <= 1'b0;
    end else if (op_end && opcode_q == `FSRA_OP_WREN) begin
      write_latch_flag_q <= 1'b1; // RULE14
    end else if (cs_rise && is_wr) begin
      write_latch_flag_q <= 1'b0; // RULE15
    end
  end

  // arming never touches the latch and lasts for one write frame only
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      vol_armed_q <= 1'b0;
    end else if (op_end && opcode_q == `FSRA_OP_WRVOL) begin
      vol_armed_q <= 1'b1; // RULE13
    end else if (cs_rise && is_wr) begin
      vol_armed_q <= 1'b0; // RULE13
    end
  end

  // ------------------------------------------------------------
  // register commit
  // ------------------------------------------------------------
  // registers four and five are live inputs and never written here
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      status_byte_one_q   <= `FSRA_RESET_SR;
      status_byte_two_q   <= `FSRA_RESET_SR;
      status_byte_three_q <= `FSRA_RESET_SR;
    end else if (commit) begin // RULE16
      case (opcode_q)
        `FSRA_OP_WR1: begin
          status_byte_one_q <= wr_data0_q;
          if (wr_bytes_q == `FSRA_WR_TWO) begin
            status_byte_two_q <= wr_data1_q; // RULE18
          end
        end
        `FSRA_OP_WR2: status_byte_two_q   <= wr_data0_q;
        `FSRA_OP_WR3: status_byte_three_q <= wr_data0_q;
        default: begin
        end
      endcase
    end
  end

endmodule

//--- verification/fsra_top_monitor.sv
`timescale 1ns/100ps
module fsra_top_monitor (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       cs_b_pin,
  input wire logic       sck_pin,
  input wire logic       so_out_q,
  input wire logic       so_oe_q,
  input wire logic       write_latch_flag_q,
  input wire logic       vol_armed_q,
  input wire logic [7:0] status_byte_two_q,
  input wire logic [7:0] status_byte_three_q
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // ----
  // link and register checks
  // ----
  a_cs_tristate: assert property (cs_b_pin [*5] |-> ##1 !so_oe_q)
    else $error("output driven after deselect");
  a_oe_in_frame: assert property ($rose(so_oe_q) |-> !cs_b_pin)
    else $error("output enabled outside frame");
  a_out_on_fall: assert property (sck_pin [*4] |-> $stable(so_out_q))
    else $error("output moved while clock high");
  a_latch_clr_idle: assert property ($fell(write_latch_flag_q) |-> cs_b_pin)
    else $error("latch cleared inside frame");
  a_latch_set_idle: assert property ($rose(write_latch_flag_q) |-> cs_b_pin)
    else $error("latch set inside frame");
  a_regs_at_idle: assert property (!$stable({status_byte_two_q, status_byte_three_q})
    |-> cs_b_pin) else $error("register changed inside frame");
  a_regs_enabled: assert property (
    !$stable({status_byte_two_q, status_byte_three_q})
    |-> $past(write_latch_flag_q) || $past(vol_armed_q))
    else $error("register written without enable");
  a_vol_no_latch: assert property ($rose(vol_armed_q) |-> $stable(write_latch_flag_q))
    else $error("volatile arm touched latch");
  c_latch: cover property ($rose(write_latch_flag_q));
  c_arm: cover property ($rose(vol_armed_q));
  c_drive: cover property ($rose(so_oe_q));
endmodule
bind fsra_top fsra_top_monitor u_fsra_top_monitor (.ref_clk(ref_clk), .rst_b(rst_b),
  .cs_b_pin(cs_b_pin), .sck_pin(sck_pin), .so_out_q(so_out_q), .so_oe_q(so_oe_q),
  .write_latch_flag_q(write_latch_flag_q), .vol_armed_q(vol_armed_q),
  .status_byte_two_q(status_byte_two_q), .status_byte_three_q(status_byte_three_q));

//--- verification/fsra_host_model.sv
`timescale 1ns/100ps
module fsra_host_model (
  input  wire logic clk,
  input  wire logic so,
  output logic      cs_b,
  output logic      sck,
  output logic      si
);
  initial begin
    cs_b = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge clk);
  endtask
  task automatic sel(input logic on);
    half();
    cs_b <= ~on;
    si   <= ~si;
    half();
    if (!on) half();
  endtask
  // sampled mid-high: the device answers a few cycles after the fall
  task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] q);
    for (int i = 7; i > 7 - n; i--) begin
      si  <= d[i];
      half();
      sck <= 1'b1;
      repeat (2) @(posedge clk);
      q[i] = so;
      repeat (2) @(posedge clk);
      sck <= 1'b0;
    end
  endtask
endmodule

//--- verification/tb_fsra_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
module tb_fsra_top;
  logic        ref_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic        cs_b_pin;
  logic        sck_pin;
  logic        si_pin;
  logic        so_hold = 1'b0;
  logic        so_out_q;
  logic        so_oe_q;
  logic        write_latch_flag_q;
  logic        vol_armed_q;
  logic [7:0]  live_sr4 = 8'hE7;
  logic [7:0]  live_sr5 = 8'h1B;
  logic [7:0]  status_byte_one_q;
  logic [7:0]  status_byte_two_q;
  logic [7:0]  status_byte_three_q;
  logic [7:0]  q;
  logic [7:0]  rb [6];
  logic [7:0]  wop [3] = '{8'h01, 8'h31, 8'h11};
  logic [7:0]  rop [3] = '{8'h05, 8'h35, 8'h15};
  logic [7:0]  val [3] = '{8'hA5, 8'h3C, 8'h96};
  int          n_fail = 0;
  int          samples_checked = 0;
  wire  [23:0] regs = {status_byte_one_q, status_byte_two_q, status_byte_three_q};
  // a released line shows the inverse of its last level, never a kind guess
  wire         so_w = so_oe_q ? so_out_q : ~so_hold;
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (so_oe_q) so_hold <= so_out_q;
  fsra_top u_fsra_top (.ref_clk(ref_clk), .rst_b(rst_b), .cs_b_pin(cs_b_pin),
    .sck_pin(sck_pin), .si_pin(si_pin), .live_sr4(live_sr4), .live_sr5(live_sr5),
    .so_out_q(so_out_q), .so_oe_q(so_oe_q), .write_latch_flag_q(write_latch_flag_q),
    .vol_armed_q(vol_armed_q), .status_byte_one_q(status_byte_one_q),
    .status_byte_two_q(status_byte_two_q), .status_byte_three_q(status_byte_three_q));
  fsra_host_model u_fsra_host_model (.clk(ref_clk), .so(so_w), .cs_b(cs_b_pin),
    .sck(sck_pin), .si(si_pin));
  // ----
  // frames
  // ----
  task automatic wr(input logic [7:0] op, input logic [15:0] d, input int nb);
    u_fsra_host_model.sel(1'b1);
    u_fsra_host_model.xfer(op, 8, q);
    u_fsra_host_model.xfer(d[15:8], nb > 8 ? 8 : nb, q);
    if (nb > 8) u_fsra_host_model.xfer(d[7:0], nb - 8, q);
    u_fsra_host_model.sel(1'b0);
  endtask
  task automatic rd(input logic [7:0] op, input logic [7:0] a, input int n);
    u_fsra_host_model.sel(1'b1);
    u_fsra_host_model.xfer(op, 8, q);
    if (op == 8'h65) begin
      u_fsra_host_model.xfer(a, 8, q);
      u_fsra_host_model.xfer(8'hC3, 8, q);
    end
    for (int i = 0; i < n; i++) u_fsra_host_model.xfer(8'h00, 8, rb[i]);
    u_fsra_host_model.sel(1'b0);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_direct();
    for (int i = 0; i < 3; i++) begin
      wr(8'h06, 16'h0000, 0);
      `CHK("latch set", 1'b1, write_latch_flag_q)
      wr(wop[i], {val[i], 8'h00}, 8);
      `CHK("latch clear", 1'b0, write_latch_flag_q)
      rd(rop[i], 8'h00, 2);
      `CHK("direct", {val[i], val[i]}, {rb[0], rb[1]})
    end
  endtask
  task automatic t_enable();
    wr(8'h31, 16'h5A00, 8);
    `CHK("no enable", 8'h3C, status_byte_two_q)
    wr(8'h50, 16'h0000, 0);
    `CHK("arm", 2'b01, {write_latch_flag_q, vol_armed_q})
    wr(8'h31, 16'h5A00, 8);
    `CHK("vol write", 8'h5A, status_byte_two_q)
    wr(8'h31, 16'hFF00, 8);
    `CHK("vol once", 8'h5A, status_byte_two_q)
  endtask
  task automatic t_abort_legacy();
    wr(8'h06, 16'h0000, 0);
    wr(8'h11, 16'h0000, 5);
    `CHK("abort", {8'h96, 1'b0}, {status_byte_three_q, write_latch_flag_q})
    wr(8'h06, 16'h0000, 0);
    wr(8'h01, 16'h8142, 16);
    `CHK("legacy", 24'h8142_96, regs)
    wr(8'h06, 16'h0000, 0);
    wr(8'h01, 16'h2400, 8);
    `CHK("one only", 24'h2442_96, regs)
  endtask
  task automatic t_indirect();
    rd(8'h65, 8'h01, 6);
    `CHK("stream", 48'h2442_96E7_1B00, {rb[0], rb[1], rb[2], rb[3], rb[4], rb[5]})
    rd(8'h65, 8'hFE, 4);
    `CHK("wrap", 32'h0000_0024, {rb[0], rb[1], rb[2], rb[3]})
    live_sr4 <= 8'h5C;
    rd(8'h65, 8'h04, 2);
    `CHK("live", 16'h5C1B, {rb[0], rb[1]})
    wr(8'h05, 16'h0000, 3);
    `CHK("cut", 1'b0, so_oe_q)
  endtask
  task automatic test_done();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK("reset", 26'h0, {regs, write_latch_flag_q, so_oe_q})
    t_direct();
    t_enable();
    t_abort_legacy();
    t_indirect();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    test_done();
  end
endmodule
